// ### rtl/fpe_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the flash program/erase controller. Definitions only.
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH

// Register offsets on the plain register port (16-bit registers)
`define FPE_ADDR_CTRL       4'h0
`define FPE_ADDR_KEY        4'h2

// Control register fields
`define FPE_BIT_START       15
`define FPE_BIT_ENABLE      14
`define FPE_BIT_ERROR       13
`define FPE_BIT_PROGRAM_ONLY_ENABLE     12
`define FPE_BIT_ERASE       6
`define FPE_CTRL_RESET      16'h0000

// Unlock key values
`define FPE_KEY_FIRST       16'h0055
`define FPE_KEY_SECOND      16'h00aa

// Operation codes (full codes and upper-nibble patterns)
`define FPE_CODE_ERASE4     6'h1a
`define FPE_CODE_ERASE2     6'h19
`define FPE_CODE_ERASE1     6'h18
`define FPE_PAT_BOOT        4'ha
`define FPE_PAT_ALL         4'h9
`define FPE_PAT_CFG         4'h5
`define FPE_PAT_EEPROM      4'h4
`define FPE_PAT_GENERAL     4'h3
`define FPE_PAT_PROG        4'h1

// Row geometry: one row spans 64 address units (32 words, step 2)
`define FPE_ROW_SHIFT       6
`define FPE_ROW_WORDS       32

// Self-timed durations
`define FPE_CLK_PERIOD_NS   10
`define FPE_ERASE_TIME_NS   2000000
`define FPE_PROG_TIME_NS    2000000
`define FPE_ERASE_CYC       ((`FPE_ERASE_TIME_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS)
`define FPE_PROG_CYC        ((`FPE_PROG_TIME_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS)

`endif

// ### rtl/fpe_pkg.sv
// Types shared by the flash program/erase controller.
// Assumes fpe_regs.svh supplies the numeric constants.
package fpe_pkg;

   // Array operation selected at start
   typedef enum logic [3:0] {
      FPE_OP_NONE       = 4'h0,
      FPE_OP_ROW_PROG   = 4'h1,
      FPE_OP_ERASE_1ROW = 4'h2,
      FPE_OP_ERASE_2ROW = 4'h3,
      FPE_OP_ERASE_4ROW = 4'h4,
      FPE_OP_ERASE_CFG  = 4'h5,
      FPE_OP_ERASE_EE   = 4'h6,
      FPE_OP_ERASE_GEN  = 4'h7,
      FPE_OP_ERASE_BOOT = 4'h8,
      FPE_OP_ERASE_ALL  = 4'h9
   } fpe_op_t;

   // Unlock tracking states
   typedef enum logic [2:0] {
      FPE_KEY_IDLE = 3'b001,
      FPE_KEY_HALF = 3'b010,
      FPE_KEY_OPEN = 3'b100
   } fpe_key_state_t;

   // Sequencer states
   typedef enum logic [1:0] {
      FPE_SEQ_IDLE = 2'b01,
      FPE_SEQ_RUN  = 2'b10
   } fpe_seq_state_t;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } fpe_bus_req_t;

   // Command to the flash array
   typedef struct packed {
      fpe_op_t     op;
      logic [23:0] addr;
      logic        pgm_only;
   } fpe_flash_cmd_t;

endpackage : fpe_pkg

// ### rtl/fpe_flash_ctrl.sv
// Flash program/erase controller: control register, unlock key,
// holding latches and self-timed sequencer with processor stall.
// Assumes the register port and latch port run on ref_clk; the serial
// programming mode pin is asynchronous and is synchronised here.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "fpe_regs.svh"

// Functional notes
// - No operation starts without prior unlock
// - Key register reads back as zero
// - Start bit launches, hardware clears on completion
// - Software cannot clear the start bit
// - Processor stalled while operation runs
// - Enable bit zero inhibits all operations
// - Error flag on improper start; clear when normal
// - Erase bit picks erase or program
// - Codes erase four, two, one rows
// - Codes erase config, EEPROM, general blocks
// - Boot and full erase only in serial mode
// - Program code writes one row from latches
// - Unassigned codes perform no operation
// - Table pointer selects affected rows
// - Program-only bit applies to EEPROM only
// - Unlock opens control write for one cycle; here only the start bit is gated, other fields write freely
// - Table writes held in latches until start
// - Row blocks aligned to their own size
module fpe_flash_ctrl
   import fpe_pkg::*;
#(
   parameter int unsigned ERASE_CYC = `FPE_ERASE_CYC,
   parameter int unsigned PROG_CYC  = `FPE_PROG_CYC
) (
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           rst_b,
   // Register port
   input  wire fpe_bus_req_t   bus_req,
   output logic [15:0]         bus_rdata,
   // Table pointer from the core
   input  wire logic [7:0]     table_page_pointer,
   input  wire logic [15:0]    table_offset,
   // Table-write latch port
   input  wire logic           latch_wr,
   input  wire logic [4:0]     latch_idx,
   input  wire logic [23:0]    latch_data,
   // Serial programming mode pin
   input  wire logic           serial_prog_pin,
   // Flash array side
   output fpe_flash_cmd_t      flash_cmd,
   output logic                flash_start,
   output logic                flash_busy,
   output logic                flash_wr_valid,
   output logic [4:0]          flash_wr_idx,
   output logic [23:0]         flash_wr_data,
   // Core side
   output logic                cpu_stall
);

   // Decode erase bit and code into an operation
   function automatic fpe_op_t fpe_decode(input logic       erase,
                                          input logic [5:0] code,
                                          input logic       serial);
      fpe_op_t op;
      op = FPE_OP_NONE;
      if (!erase) begin
         if (code[5:2] == `FPE_PAT_PROG) begin
            op = FPE_OP_ROW_PROG;
         end
      end else begin
         if (code == `FPE_CODE_ERASE4) begin
            op = FPE_OP_ERASE_4ROW;
         end else if (code == `FPE_CODE_ERASE2) begin
            op = FPE_OP_ERASE_2ROW;
         end else if (code == `FPE_CODE_ERASE1) begin
            op = FPE_OP_ERASE_1ROW;
         end else if (code[5:2] == `FPE_PAT_CFG) begin
            op = FPE_OP_ERASE_CFG;
         end else if (code[5:2] == `FPE_PAT_EEPROM) begin
            op = FPE_OP_ERASE_EE;
         end else if (code[5:2] == `FPE_PAT_GENERAL) begin
            op = FPE_OP_ERASE_GEN;
         end else if (serial && code[5:2] == `FPE_PAT_BOOT) begin
            op = FPE_OP_ERASE_BOOT;
         end else if (serial && code[5:2] == `FPE_PAT_ALL) begin
            op = FPE_OP_ERASE_ALL;
         end
      end
      return op;
   endfunction : fpe_decode

   // Align a pointer down to the block size of a row operation; other operations pass it unchanged
   function automatic logic [23:0] fpe_align(input logic [23:0] addr,
                                             input fpe_op_t     op);
      logic [23:0] mask;
      mask = 24'hffffff;
      unique case (op)
         FPE_OP_ROW_PROG,
         FPE_OP_ERASE_1ROW : mask = 24'hffffff << `FPE_ROW_SHIFT;
         FPE_OP_ERASE_2ROW : mask = 24'hffffff << (`FPE_ROW_SHIFT + 1);
         FPE_OP_ERASE_4ROW : mask = 24'hffffff << (`FPE_ROW_SHIFT + 2);
         default           : mask = 24'hffffff;
      endcase
      return addr & mask;
   endfunction : fpe_align

   fpe_key_state_t  key_ff;
   fpe_key_state_t  nxt_key;
   fpe_seq_state_t  seq_ff;
   logic            ser_meta_ff;
   logic            ser_sync_ff;
   logic            start_ff;
   logic            enable_ff;
   logic            error_ff;
   logic            program_only_enable_ff;
   logic            erase_ff;
   logic [5:0]      code_ff;
   logic [31:0]     tmr_ff;
   logic [4:0]      strm_ff;
   logic            strm_on_ff;
   logic [15:0]     rdata_ff;
   fpe_flash_cmd_t  cmd_ff;
   logic            fstart_ff;
   logic            wvalid_ff;
   logic [4:0]      widx_ff;
   logic [23:0]     wdata_ff;
   logic [23:0]     latch_mem [`FPE_ROW_WORDS];
   logic            wr_ctrl;
   logic            wr_key;
   logic            start_try;
   logic            start_ok;
   logic            done;
   fpe_op_t         nxt_op;
   // Literal copy so reset fields can be bit-selected
   localparam logic [15:0] CTRL_RST = `FPE_CTRL_RESET;

   // Port decode and start qualification
   assign wr_ctrl   = bus_req.wr && (bus_req.addr == `FPE_ADDR_CTRL);
   assign wr_key    = bus_req.wr && (bus_req.addr == `FPE_ADDR_KEY);
   assign start_try = wr_ctrl && bus_req.wdata[`FPE_BIT_START] && !start_ff;
   assign start_ok  = start_try && (key_ff == FPE_KEY_OPEN)
                      && bus_req.wdata[`FPE_BIT_ENABLE];
   assign nxt_op    = fpe_decode(bus_req.wdata[`FPE_BIT_ERASE], bus_req.wdata[5:0],
                                 ser_sync_ff);
   assign done      = (seq_ff == FPE_SEQ_RUN) && (tmr_ff == 32'h1);

   // Mode pin synchroniser; only the second stage is used
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ser_meta_ff <= 1'b0;
         ser_sync_ff <= 1'b0;
      end else begin
         ser_meta_ff <= serial_prog_pin;
         ser_sync_ff <= ser_meta_ff;
      end
   end

   // Unlock tracker: any write other than a key write of either key value breaks a half sequence
   always_comb begin
      nxt_key = FPE_KEY_IDLE;
      unique case (key_ff)
         FPE_KEY_IDLE : begin
            if (wr_key && bus_req.wdata == `FPE_KEY_FIRST) begin
               nxt_key = FPE_KEY_HALF;
            end
         end
         FPE_KEY_HALF : begin
            if (!bus_req.wr) begin
               nxt_key = FPE_KEY_HALF;
            end else if (wr_key && bus_req.wdata == `FPE_KEY_SECOND) begin
               nxt_key = FPE_KEY_OPEN;
            end else if (wr_key && bus_req.wdata == `FPE_KEY_FIRST) begin
               nxt_key = FPE_KEY_HALF;
            end
         end
         FPE_KEY_OPEN : begin
            // Window lasts exactly one cycle
            if (wr_key && bus_req.wdata == `FPE_KEY_FIRST) begin
               nxt_key = FPE_KEY_HALF;
            end
         end
         default : nxt_key = FPE_KEY_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         key_ff <= FPE_KEY_IDLE;
      end else begin
         key_ff <= nxt_key;
      end
   end

   // Configuration bits; frozen while an operation runs
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_ff  <= CTRL_RST[`FPE_BIT_ENABLE];
         program_only_enable_ff <= CTRL_RST[`FPE_BIT_PROGRAM_ONLY_ENABLE];
         erase_ff   <= CTRL_RST[`FPE_BIT_ERASE];
         code_ff    <= CTRL_RST[5:0];
      end else if (wr_ctrl && !start_ff) begin
         enable_ff  <= bus_req.wdata[`FPE_BIT_ENABLE];
         program_only_enable_ff <= bus_req.wdata[`FPE_BIT_PROGRAM_ONLY_ENABLE];
         erase_ff   <= bus_req.wdata[`FPE_BIT_ERASE];
         code_ff    <= bus_req.wdata[5:0];
      end
   end

   // Start bit: set only by a qualified write, cleared only by hardware
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_ff <= CTRL_RST[`FPE_BIT_START];
      end else if (start_ok) begin
         start_ff <= 1'b1;
      end else if (done) begin
         start_ff <= 1'b0;
      end
   end

   // Error flag: hardware set beats every clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         error_ff <= CTRL_RST[`FPE_BIT_ERROR];
      end else if (start_try && !start_ok) begin
         error_ff <= 1'b1;
      end else if (start_ok) begin
         error_ff <= 1'b0;
      end else if (wr_ctrl) begin
         error_ff <= bus_req.wdata[`FPE_BIT_ERROR];
      end
   end

   // Sequencer and operation timer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_ff <= FPE_SEQ_IDLE;
         tmr_ff <= 32'h0;
      end else begin
         unique case (seq_ff)
            FPE_SEQ_IDLE : begin
               if (start_ok) begin
                  seq_ff <= FPE_SEQ_RUN;
                  if (nxt_op == FPE_OP_NONE) begin
                     tmr_ff <= 32'h1;
                  end else if (nxt_op == FPE_OP_ROW_PROG) begin
                     tmr_ff <= 32'(PROG_CYC);
                  end else begin
                     tmr_ff <= 32'(ERASE_CYC);
                  end
               end
            end
            FPE_SEQ_RUN : begin
               tmr_ff <= tmr_ff - 32'h1;
               if (done) begin
                  seq_ff <= FPE_SEQ_IDLE;
               end
            end
         endcase
      end
   end

   // Command capture; a no-op never reaches the array
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_ff    <= '{op: FPE_OP_NONE, addr: 24'h0, pgm_only: 1'b0};
         fstart_ff <= 1'b0;
      end else begin
         fstart_ff <= start_ok && (nxt_op != FPE_OP_NONE);
         if (start_ok) begin
            cmd_ff.op       <= nxt_op;
            cmd_ff.addr     <= fpe_align({table_page_pointer, table_offset},
                                         nxt_op);
            cmd_ff.pgm_only <= bus_req.wdata[`FPE_BIT_PROGRAM_ONLY_ENABLE]
                               && (nxt_op == FPE_OP_ERASE_EE);
         end
      end
   end

   // Holding latches; locked while the array is busy
   always_ff @(posedge ref_clk) begin
      if (latch_wr && seq_ff == FPE_SEQ_IDLE) begin
         latch_mem[latch_idx] <= latch_data;
      end
   end

   // Stream latch contents to the array during a row program
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         strm_on_ff <= 1'b0;
         strm_ff    <= 5'h0;
         wvalid_ff  <= 1'b0;
         widx_ff    <= 5'h0;
         wdata_ff   <= 24'h0;
      end else begin
         if (start_ok && nxt_op == FPE_OP_ROW_PROG) begin
            strm_on_ff <= 1'b1;
            strm_ff    <= 5'h0;
         end else if (strm_on_ff) begin
            strm_ff <= strm_ff + 5'h1;
            if (strm_ff == 5'h1f) begin
               strm_on_ff <= 1'b0;
            end
         end
         wvalid_ff <= strm_on_ff;
         widx_ff   <= strm_ff;
         if (strm_on_ff) begin
            wdata_ff <= latch_mem[strm_ff];
         end
      end
   end

   // Read data one cycle after the strobe; key reads as zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 16'h0;
      end else if (bus_req.rd) begin
         if (bus_req.addr == `FPE_ADDR_CTRL) begin
            rdata_ff <= {start_ff, enable_ff, error_ff, program_only_enable_ff, 5'h00,
                         erase_ff, code_ff};
         end else begin
            rdata_ff <= 16'h0;
         end
      end
   end

   // Outputs
   assign bus_rdata      = rdata_ff;
   assign flash_cmd      = cmd_ff;
   assign flash_start    = fstart_ff;
   assign flash_busy     = (seq_ff == FPE_SEQ_RUN);
   assign cpu_stall      = (seq_ff == FPE_SEQ_RUN);
   assign flash_wr_valid = wvalid_ff;
   assign flash_wr_idx   = widx_ff;
   assign flash_wr_data  = wdata_ff;

   // Checks
   sequence s_unlock;
      (wr_key && bus_req.wdata == `FPE_KEY_FIRST) ##1
      (wr_key && bus_req.wdata == `FPE_KEY_SECOND);
   endsequence

   sequence s_go;
      wr_ctrl && bus_req.wdata[`FPE_BIT_START] && bus_req.wdata[`FPE_BIT_ENABLE]
      && !start_ff;
   endsequence

   a_unlock_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_unlock ##1 s_go |=> start_ff && cpu_stall)
      else $error("unlocked start did not launch");
   a_no_key_no_run: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_try && key_ff != FPE_KEY_OPEN |=> !start_ff && error_ff)
      else $error("start accepted without unlock");
   a_window_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_unlock ##1 !bus_req.wr ##1 s_go |=> !start_ff)
      else $error("unlock window stayed open");
   a_bad_second: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (wr_key && bus_req.wdata == `FPE_KEY_FIRST) ##1
      (wr_key && bus_req.wdata != `FPE_KEY_SECOND && bus_req.wdata != `FPE_KEY_FIRST)
      |=> key_ff == FPE_KEY_IDLE)
      else $error("partial unlock kept");
   a_enable_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_try && !bus_req.wdata[`FPE_BIT_ENABLE] |=> !start_ff && !flash_start)
      else $error("start with enable low");
   a_start_held: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_ff && !done |=> start_ff)
      else $error("start bit cleared early");
   a_stall_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_ff |-> cpu_stall && flash_busy)
      else $error("no stall while busy");
   a_nop_short: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_ok && nxt_op == FPE_OP_NONE |=> start_ff && !flash_start ##1 !start_ff)
      else $error("no-op code not handled");
   a_err_cleared: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_ok |=> !error_ff)
      else $error("error flag not cleared on start");
   a_key_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      bus_req.rd && bus_req.addr == `FPE_ADDR_KEY |=> bus_rdata == 16'h0)
      else $error("key register readable");
   a_row_align: assert property (@(posedge ref_clk) disable iff (!rst_b)
      flash_start && flash_cmd.op == FPE_OP_ERASE_4ROW |-> flash_cmd.addr[7:0] == 8'h00)
      else $error("four-row erase misaligned");
   a_serial_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
      start_ok && !ser_sync_ff |=> flash_cmd.op != FPE_OP_ERASE_BOOT
      && flash_cmd.op != FPE_OP_ERASE_ALL)
      else $error("serial-only erase in run time");

endmodule : fpe_flash_ctrl

// ### sim/flash_program_erase_ctrl_tb_top.sv
// Self-checking bench for the flash program/erase controller.
// Assumes fpe_pkg and fpe_regs.svh are compiled first; single 100 MHz clock.
`timescale 1ns/1ns
`include "fpe_regs.svh"
module flash_program_erase_ctrl_tb_top import fpe_pkg::*; ();
   // Short self-timed counts keep the run brief
   localparam int ERASE_N = 40;
   localparam int PROG_N  = 48;
   // Design inputs
   logic           ref_clk            = 1'b0;
   logic           rst_b              = 1'b0;
   fpe_bus_req_t   bus_req            = '0;
   logic [7:0]     table_page_pointer = 8'h12;
   logic [15:0]    table_offset       = 16'h34c6;
   logic           latch_wr           = 1'b0;
   logic [4:0]     latch_idx          = 5'h00;
   logic [23:0]    latch_data         = 24'h000000;
   logic           serial_prog_pin    = 1'b0;
   // Design outputs
   logic [15:0]    bus_rdata;
   fpe_flash_cmd_t flash_cmd;
   logic           flash_start;
   logic           flash_busy;
   logic           flash_wr_valid;
   logic [4:0]     flash_wr_idx;
   logic [23:0]    flash_wr_data;
   logic           cpu_stall;
   // Bookkeeping and latch image
   int             err_count = 0;
   int             tests_run = 0;
   int             busy_cnt  = 0;
   int             wr_cnt    = 0;
   logic [23:0]    lat [32];

   // Free-running core clock
   always #5 ref_clk = ~ref_clk;

   fpe_flash_ctrl #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) i_fpe_flash_ctrl (
      .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .table_page_pointer(table_page_pointer), .table_offset(table_offset),
      .latch_wr(latch_wr), .latch_idx(latch_idx), .latch_data(latch_data),
      .serial_prog_pin(serial_prog_pin), .flash_cmd(flash_cmd), .flash_start(flash_start),
      .flash_busy(flash_busy), .flash_wr_valid(flash_wr_valid),
      .flash_wr_idx(flash_wr_idx), .flash_wr_data(flash_wr_data), .cpu_stall(cpu_stall));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   // Strobe left high so writes can follow each other with no gap
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      d = bus_rdata;
      // Return on an edge so the next request starts right after it
      @(posedge ref_clk);
   endtask : rd

   task automatic unlock();
      wr(`FPE_ADDR_KEY, `FPE_KEY_FIRST);
      wr(`FPE_ADDR_KEY, `FPE_KEY_SECOND);
   endtask : unlock

   // Busy cycles seen at each edge; covers no-op and long runs alike
   always @(posedge ref_clk) begin
      if (flash_busy === 1'b1) busy_cnt++;
   end

   // Row stream must replay the latch image in index order
   always @(posedge ref_clk) begin
      if (flash_wr_valid === 1'b1) begin
         chk(flash_wr_idx, wr_cnt[4:0], "stream index");
         chk(flash_wr_data, lat[wr_cnt[4:0]], "stream data");
         wr_cnt++;
      end
   end

   // Core stall must track the sequencer exactly
   always @(negedge ref_clk) begin
      if (rst_b) chk(cpu_stall, flash_busy, "stall");
   end

   // Entered right after the sampling edge of a start write that must fail
   task automatic refused(input string msg);
      logic [15:0] d;
      bus_req <= '0;
      #1;
      chk(flash_start, 1'b0, msg);
      @(posedge ref_clk);
      #1;
      chk(flash_busy, 1'b0, msg);
      @(posedge ref_clk);
      rd(`FPE_ADDR_CTRL, d);
      chk(d & 16'ha000, 16'h2000, msg);
      $display("Test %s done", msg);
   endtask : refused

   // Unlock, start, check the command, then time the busy span
   task automatic run(input logic [15:0] ctrl, input fpe_op_t op, input logic [23:0] mask,
                      input int cyc, input logic pg, input bit poke, input string msg);
      logic [15:0] d;
      int          n;
      busy_cnt = 0;
      wr_cnt = 0;
      unlock();
      wr(`FPE_ADDR_CTRL, ctrl);
      bus_req <= '0;
      #1;
      chk(flash_start, op != FPE_OP_NONE, msg);
      chk(flash_busy, 1'b1, msg);
      chk(cpu_stall, 1'b1, msg);
      if (op != FPE_OP_NONE) begin
         chk(flash_cmd.op, op, msg);
         chk(flash_cmd.pgm_only, pg, msg);
         if (mask != 0) chk(flash_cmd.addr, {table_page_pointer, table_offset} & mask, msg);
      end
      if (poke) begin
         @(posedge ref_clk);
         wr(`FPE_ADDR_CTRL, 16'h0000);
         rd(`FPE_ADDR_CTRL, d);
         chk(d[15], 1'b1, msg);
      end
      n = 0;
      while (flash_busy !== 1'b0 && n < 1000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(cpu_stall, 1'b0, msg);
      @(posedge ref_clk);
      chk(busy_cnt, cyc, msg);
      chk(wr_cnt, (op == FPE_OP_ROW_PROG) ? 32 : 0, msg);
      rd(`FPE_ADDR_CTRL, d);
      chk(d[15], 1'b0, msg);
      if (op != FPE_OP_NONE) chk(d, ctrl & 16'h7fff, msg);
      $display("Test %s done", msg);
   endtask : run

   task automatic t_reset();
      logic [15:0] d;
      rd(`FPE_ADDR_CTRL, d);
      chk(d, `FPE_CTRL_RESET, "ctrl reset");
      unlock();
      rd(`FPE_ADDR_KEY, d);
      chk(d, 16'h0000, "key read");
      rd(4'h6, d);
      chk(d, 16'h0000, "unmapped read");
      $display("Test reset done");
   endtask : t_reset

   task automatic t_refuse();
      wr(`FPE_ADDR_CTRL, 16'hc058);
      refused("no unlock");
      unlock();
      wr(`FPE_ADDR_CTRL, 16'h8058);
      refused("enable low");
      wr(`FPE_ADDR_KEY, `FPE_KEY_FIRST);
      wr(`FPE_ADDR_KEY, 16'h0011);
      wr(`FPE_ADDR_KEY, `FPE_KEY_SECOND);
      wr(`FPE_ADDR_CTRL, 16'hc058);
      refused("bad second key");
      unlock();
      // A read between the key and the start still closes the window
      bus_req <= '{addr: `FPE_ADDR_CTRL, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      wr(`FPE_ADDR_CTRL, 16'hc058);
      refused("late start");
   endtask : t_refuse

   // Every erase code family, with the don't-care bits varied
   task automatic t_codes();
      run(16'hc058, FPE_OP_ERASE_1ROW, 24'hffffc0, ERASE_N, 1'b0, 1'b1, "1 row");
      run(16'hc059, FPE_OP_ERASE_2ROW, 24'hffff80, ERASE_N, 1'b0, 1'b0, "2 rows");
      run(16'hc05a, FPE_OP_ERASE_4ROW, 24'hffff00, ERASE_N, 1'b0, 1'b0, "4 rows");
      run(16'hc057, FPE_OP_ERASE_CFG, 24'h0, ERASE_N, 1'b0, 1'b0, "cfg");
      run(16'hd051, FPE_OP_ERASE_EE, 24'h0, ERASE_N, 1'b1, 1'b0, "eeprom");
      run(16'hc04e, FPE_OP_ERASE_GEN, 24'h0, ERASE_N, 1'b0, 1'b0, "general");
      run(16'hc068, FPE_OP_NONE, 24'h0, 1, 1'b0, 1'b0, "boot locked");
      run(16'hc064, FPE_OP_NONE, 24'h0, 1, 1'b0, 1'b0, "all locked");
      run(16'hc07f, FPE_OP_NONE, 24'h0, 1, 1'b0, 1'b0, "unassigned");
      run(16'hc018, FPE_OP_NONE, 24'h0, 1, 1'b0, 1'b0, "prog 1 row code");
      run(16'hd058, FPE_OP_ERASE_1ROW, 24'hffffc0, ERASE_N, 1'b0, 1'b0, "pgm bit");
   endtask : t_codes

   // Latches loaded in reverse order, nothing may reach the array yet
   task automatic t_prog();
      wr_cnt = 0;
      for (int i = 31; i >= 0; i--) begin
         lat[i] = {8'h3c, i[7:0], ~i[7:0]};
         latch_wr   <= 1'b1;
         latch_idx  <= i[4:0];
         latch_data <= lat[i];
         @(posedge ref_clk);
      end
      latch_wr <= 1'b0;
      chk(wr_cnt, 0, "latch hold");
      run(16'hc006, FPE_OP_ROW_PROG, 24'hffffc0, PROG_N, 1'b0, 1'b0, "row prog");
   endtask : t_prog

   // Boot and full erase only once serial mode is seen
   task automatic t_serial();
      serial_prog_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      run(16'hc06b, FPE_OP_ERASE_BOOT, 24'h0, ERASE_N, 1'b0, 1'b0, "boot");
      run(16'hc064, FPE_OP_ERASE_ALL, 24'h0, ERASE_N, 1'b0, 1'b0, "all");
      serial_prog_pin <= 1'b0;
   endtask : t_serial

   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_refuse();
      t_codes();
      t_prog();
      t_serial();
      stop_test();
   end

   // 14 operations of under 60 cycles; wide margin over that
   initial begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule : flash_program_erase_ctrl_tb_top
